// ---- pkg/srb_defines.vh ----
// register offsets, field positions and reset values for the status readback block
`ifndef SRB_DEFINES_VH
`define SRB_DEFINES_VH

// register indexes; the apb byte address is four times the index
`define SRB_IDX_IRQ_REQ       8'h08
`define SRB_IDX_CLK_LOSS      8'h09
`define SRB_IDX_SF_ALARM      8'h36
`define SRB_IDX_TEST_PAT      8'h3d
`define SRB_IDX_TEST_FLAGS    8'h3e
`define SRB_IDX_FRAME_RD      8'h67
`define SRB_IDX_UC_OLD        8'h68
`define SRB_IDX_UC_NEW        8'h69
`define SRB_IDX_UC_STAT       8'h6a
`define SRB_IDX_LIVE          8'h6e
`define SRB_IDX_COEF_HI       8'h7b
// added control registers
`define SRB_IDX_IRQ_MASK      8'h80
`define SRB_IDX_CTRL          8'h81

// interrupt source bit positions
`define SRB_BIT_WATCHDOG_IRQ          6
`define SRB_BIT_SYNC          5
`define SRB_BIT_COEF          4
`define SRB_BIT_TEST          3
`define SRB_BIT_TIMER         2
`define SRB_BIT_UCHAN         1
`define SRB_BIT_SLOTMON       0

// control register field positions
`define SRB_CTRL_SLOT16_BIT   5
`define SRB_CTRL_FSEL_HI      4
`define SRB_CTRL_FSEL_LO      0

// reset values
`define SRB_RST_MASK          7'h00
`define SRB_RST_CTRL          6'h00
`define SRB_RST_BYTE          8'h00

// frame memory depth
`define SRB_FRAMES            32
`define SRB_FRAME_AW          5

`endif

// ---- design/srb_frame_ram.v ----
// user-channel frame memory with two registered read ports
`timescale 1ns/1ps
module srb_frame_ram
(
    // clock
    input  wire       sys_clk,
    // write port
    input  wire       wr_en,
    input  wire [4:0] wr_addr,
    input  wire [7:0] wr_data,
    // read port a
    input  wire [4:0] rd_addr_a,
    output reg  [7:0] rd_data_a,
    // read port b
    input  wire [4:0] rd_addr_b,
    output reg  [7:0] rd_data_b
);

    reg [7:0] mem [0:31];

    // write and registered reads
    always @(posedge sys_clk)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
        rd_data_a <= mem[rd_addr_a];
        rd_data_b <= mem[rd_addr_b];
    end

endmodule // srb_frame_ram

// ---- design/srb_status_regs.v ----
// status and interrupt readback register group with apb slave
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "srb_defines.vh"

// Functional notes
// - clock loss flags read one per missing clock
// - request register holds seven sources, bits 6..0
// - any set request bit raises interrupt pin
// - reading request register clears bits and pin
// - mask bit blocks source setting request bit
// - live register mirrors sources, same order
// - bit2 reads one only when enable valid
// - bit1 reads one when timeslot enabled and enable valid
// - bit0 reads one when superframe not synchronised and slot16 on
// - alarm zero when synced or slot16 off
// - test pattern register shows seven-bit amplitude
// - test status holds eight flags in order
// - bit7 shows tone with phase reversal
// - bit6 shows tone with or without reversal
// - loss bit one only above threshold
// - remaining flags nonlinear, freeze, reset, fast, silence
// - frame readback returns selected frame data
// - change captures previous value
// - change captures new value and frame number
// - coefficient data read acknowledges coefficient interrupt
module srb_status_regs
(
    // clock and reset
    input  wire        sys_clk,
    input  wire        rst,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // clock presence, from pins or other domains
    input  wire        ref_clock_external,
    input  wire        ref_clock_normal,
    input  wire        ref_clock_fallback,
    input  wire        system_clock_input,
    input  wire        clock_sixteen_mhz,
    input  wire        clock_thirtytwo_mhz,
    // interrupt sources, same clock
    input  wire        watchdog_irq,
    input  wire        frame_sync_input,
    input  wire        coefficient_ready,
    input  wire        test_terminated,
    input  wire        timer_expired,
    input  wire        slot_monitor,
    // coefficient read acknowledge
    output reg         coefficient_ack,
    // superframe and slot enable status
    input  wire        slot_enable_valid,
    input  wire        slot_enabled,
    input  wire        superframe_unsync,
    // background test results
    input  wire [6:0]  test_output_pattern,
    input  wire        tone_phase_reversal,
    input  wire        answer_tone_seen,
    input  wire        nonlinear_processor_on,
    input  wire        filter_frozen,
    input  wire        filter_cleared,
    input  wire [4:0]  echo_loss_level,
    input  wire        fast_convergence,
    input  wire        silence_detected,
    input  wire [4:0]  bypass_threshold,
    // user-channel input data
    input  wire        uc_valid,
    input  wire [4:0]  uc_frame,
    input  wire [7:0]  uc_data,
    // interrupt pin and configuration out
    output reg         irq_out,
    output reg         slot16_signalling_on,
    output reg  [4:0]  frame_select
);

    // register index of an apb byte address
    function [7:0] reg_index;
        input [11:0] addr;
        begin
            reg_index = addr[9:2];
        end
    endfunction

    // one for every mapped register index except the coefficient high byte, zero for holes
    function reg_known;
        input [7:0] ix;
        begin
            case (ix)
                `SRB_IDX_IRQ_REQ,
                `SRB_IDX_CLK_LOSS,
                `SRB_IDX_SF_ALARM,
                `SRB_IDX_TEST_PAT,
                `SRB_IDX_TEST_FLAGS,
                `SRB_IDX_FRAME_RD,
                `SRB_IDX_UC_OLD,
                `SRB_IDX_UC_NEW,
                `SRB_IDX_UC_STAT,
                `SRB_IDX_LIVE,
                `SRB_IDX_IRQ_MASK,
                `SRB_IDX_CTRL:
                    reg_known = 1'b1;
                default:
                    reg_known = 1'b0;
            endcase
        end
    endfunction

    // settled level: follow stages two and three only while they agree, else hold
    function [5:0] settle;
        input [5:0] s2;
        input [5:0] s3;
        input [5:0] held;
        begin
            settle = (s2 & s3) | (held & (s2 ^ s3));
        end
    endfunction

    // three-stage synchroniser, change counts once stages two and three agree
    reg  [5:0] clk_s1_ff;
    reg  [5:0] clk_s2_ff;
    reg  [5:0] clk_s3_ff;
    reg  [5:0] clk_loss_ff;
    wire [5:0] clk_raw = {ref_clock_external, ref_clock_normal, ref_clock_fallback,
                          system_clock_input, clock_sixteen_mhz, clock_thirtytwo_mhz};

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            clk_s1_ff   <= 6'h00;
            clk_s2_ff   <= 6'h00;
            clk_s3_ff   <= 6'h00;
            clk_loss_ff <= 6'h3f;
        end
        else
        begin
            clk_s1_ff <= clk_raw;
            clk_s2_ff <= clk_s1_ff;
            clk_s3_ff <= clk_s2_ff;
            // agreed level; input high means clock present, flag one when missing
            clk_loss_ff <= settle(~clk_s2_ff, ~clk_s3_ff, clk_loss_ff);
        end
    end

    // apb decode
    wire       acc_ph  = psel & penable;
    wire       rd_acc  = acc_ph & ~pwrite;
    wire       wr_acc  = acc_ph & pwrite;
    wire [7:0] idx     = reg_index(paddr);
    wire       rd_irq  = rd_acc & (idx == `SRB_IDX_IRQ_REQ);
    wire       rd_ucst = rd_acc & (idx == `SRB_IDX_UC_STAT);

    // user-channel change tracking
    reg  [7:0] uc_old_ff;
    reg  [7:0] uc_new_ff;
    reg  [4:0] uc_fidx_ff;
    reg        uc_live_ff;
    reg        uc_lost_ff;
    reg        uc_pend_ff;
    reg  [4:0] uc_frame_ff;
    reg  [7:0] uc_data_ff;
    reg [31:0] uc_seen_ff;
    wire [7:0] ram_old;
    wire [7:0] ram_rd;

    // memory keeps last value per frame; port a reads the frame being updated
    srb_frame_ram u_ram
    (
        .sys_clk   (sys_clk),
        .wr_en     (uc_pend_ff),
        .wr_addr   (uc_frame_ff),
        .wr_data   (uc_data_ff),
        .rd_addr_a (uc_frame),
        .rd_data_a (ram_old),
        .rd_addr_b (frame_select),
        .rd_data_b (ram_rd)
    );

    // unwritten frames hold no defined value, so their first sample is no change
    wire uc_change = uc_pend_ff & uc_seen_ff[uc_frame_ff] &
                     (ram_old != uc_data_ff);

    // capture old and new values on change
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            uc_pend_ff  <= 1'b0;
            uc_frame_ff <= 5'h00;
            uc_data_ff  <= 8'h00;
            uc_old_ff   <= 8'h00;
            uc_new_ff   <= 8'h00;
            uc_fidx_ff  <= 5'h00;
            uc_live_ff  <= 1'b0;
            uc_lost_ff  <= 1'b0;
            uc_seen_ff  <= 32'h00000000;
        end
        else
        begin
            uc_pend_ff  <= uc_valid;
            uc_frame_ff <= uc_frame;
            uc_data_ff  <= uc_data;
            // a frame's first sample only seeds the memory
            if (uc_pend_ff)
                uc_seen_ff[uc_frame_ff] <= 1'b1;
            if (uc_change & ~uc_live_ff)
            begin
                uc_old_ff  <= ram_old;
                uc_new_ff  <= uc_data_ff;
                uc_fidx_ff <= uc_frame_ff;
                uc_live_ff <= 1'b1;
            end
            else if (rd_ucst)
                uc_live_ff <= 1'b0;
            // change while still pending: possible data loss
            if (uc_change & uc_live_ff)
                uc_lost_ff <= 1'b1;
            else if (rd_ucst)
                uc_lost_ff <= 1'b0;
        end
    end

    // live source vector in request bit order
    wire [6:0] src_live = {watchdog_irq, frame_sync_input, coefficient_ready, test_terminated,
                           timer_expired, uc_live_ff, slot_monitor};

    // interrupt request, mask and pin
    reg  [6:0] irq_req_ff;
    reg  [6:0] irq_mask_ff;
    reg  [6:0] src_prev_ff;
    reg  [6:0] live_ff;
    wire [6:0] src_rise = src_live & ~src_prev_ff;
    wire [6:0] src_set  = src_rise & ~irq_mask_ff;
    reg  [6:0] nxt_irq_req;

    always @*
    begin
        nxt_irq_req = irq_req_ff;
        if (rd_irq)
            nxt_irq_req = 7'h00;
        nxt_irq_req = nxt_irq_req | src_set;      // set wins over read clear
    end

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            irq_req_ff  <= 7'h00;
            src_prev_ff <= 7'h00;
            live_ff     <= 7'h00;
            irq_out     <= 1'b0;
        end
        else
        begin
            irq_req_ff  <= nxt_irq_req;
            src_prev_ff <= src_live;
            live_ff     <= src_live;
            irq_out     <= |nxt_irq_req;
        end
    end

    // writable control: mask, slot16 enable, frame select
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            irq_mask_ff          <= `SRB_RST_MASK;
            slot16_signalling_on <= 1'b0;
            frame_select         <= 5'h00;
        end
        else if (wr_acc & (idx == `SRB_IDX_IRQ_MASK))
            irq_mask_ff <= pwdata[6:0];
        else if (wr_acc & (idx == `SRB_IDX_CTRL))
        begin
            slot16_signalling_on <= pwdata[`SRB_CTRL_SLOT16_BIT];
            frame_select         <= pwdata[`SRB_CTRL_FSEL_HI:`SRB_CTRL_FSEL_LO];
        end
    end

    // superframe alarm and test flags
    wire       sf_alarm = superframe_unsync & slot16_signalling_on;
    wire [2:0] sf_stat  = {slot_enable_valid,
                           slot_enable_valid & slot_enabled, sf_alarm};
    wire       loss_hi  = (echo_loss_level > bypass_threshold);
    wire [7:0] t_flags  = {tone_phase_reversal,
                           answer_tone_seen | tone_phase_reversal,
                           nonlinear_processor_on, filter_frozen, filter_cleared,
                           loss_hi, fast_convergence, silence_detected};

    // read multiplexer, unused bits zero
    reg [31:0] nxt_rdata;
    always @*
    begin
        nxt_rdata = 32'h00000000;
        case (idx)
            `SRB_IDX_IRQ_REQ:    nxt_rdata = {25'h0000000, irq_req_ff};
            `SRB_IDX_CLK_LOSS:   nxt_rdata = {26'h0000000, clk_loss_ff};
            `SRB_IDX_SF_ALARM:   nxt_rdata = {29'h00000000, sf_stat};
            `SRB_IDX_TEST_PAT:   nxt_rdata = {25'h0000000, test_output_pattern};
            `SRB_IDX_TEST_FLAGS: nxt_rdata = {24'h000000, t_flags};
            `SRB_IDX_FRAME_RD:   nxt_rdata = {24'h000000, ram_rd};
            `SRB_IDX_UC_OLD:     nxt_rdata = {24'h000000, uc_old_ff};
            `SRB_IDX_UC_NEW:     nxt_rdata = {24'h000000, uc_new_ff};
            `SRB_IDX_UC_STAT:    nxt_rdata = {25'h0000000, uc_lost_ff, 1'b0, uc_fidx_ff};
            `SRB_IDX_LIVE:       nxt_rdata = {25'h0000000, live_ff};
            `SRB_IDX_IRQ_MASK:   nxt_rdata = {25'h0000000, irq_mask_ff};
            `SRB_IDX_CTRL:       nxt_rdata = {26'h0000000, slot16_signalling_on, frame_select};
            default:             nxt_rdata = 32'h00000000;
        endcase
    end

    // apb answer: no wait state, data registered at the edge that opens the access phase
    wire known = reg_known(idx);

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            prdata          <= 32'h00000000;
            pready          <= 1'b0;
            pslverr         <= 1'b0;
            coefficient_ack <= 1'b0;
        end
        else
        begin
            pready  <= psel & ~penable;
            prdata  <= (psel & ~penable & ~pwrite) ? nxt_rdata : 32'h00000000;
            pslverr <= psel & ~penable & ~known;
            // acknowledge pulse when the high coefficient byte address is read
            coefficient_ack <= acc_ph & pready & ~pwrite & (idx == `SRB_IDX_COEF_HI);
        end
    end

endmodule // srb_status_regs

// ---- sim/srb_checker.sv ----
// concurrent checks on the ports of the status readback block
`timescale 1ns/1ps
module srb_checker
(
    // apb
    input wire        sys_clk, rst, psel, penable, pwrite, pready, pslverr,
    input wire [11:0] paddr,
    input wire [31:0] pwdata, prdata,
    // sources and status
    input wire        watchdog_irq, frame_sync_input, coefficient_ready, test_terminated, timer_expired,
    input wire        slot_monitor, uc_valid, irq_out, coefficient_ack, slot16_signalling_on,
    input wire        slot_enable_valid, slot_enabled, superframe_unsync
);
    // completed transfers and source rising edges
    wire        xfer_end = psel & penable & pready;
    wire        rd_end   = xfer_end & ~pwrite;
    wire        irq_rd   = rd_end & (paddr == 12'h020);
    wire  [6:0] src      = {watchdog_irq, frame_sync_input, coefficient_ready, test_terminated,
                            timer_expired, 1'b0, slot_monitor};
    logic [6:0] src_ff, mask_ff;
    logic [2:0] act_ff;
    wire  [6:0] rise     = src & ~src_ff;
    // previous sources, mask shadow, recent activity
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            src_ff  <= 7'h00;
            mask_ff <= 7'h00;
            act_ff  <= 3'h0;
        end
        else
        begin
            src_ff <= src;
            act_ff <= {act_ff[1:0], (|rise) | uc_valid};
            if (xfer_end & pwrite & (paddr == 12'h200))
                mask_ff <= pwdata[6:0];
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    setup_answer_a: assert property (psel & ~penable |=> pready)
        else $error("no answer after setup");
    ready_place_a: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    upper_zero_a: assert property (rd_end |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    irq_raise_a: assert property (|(rise & ~mask_ff) |-> ##[1:2] irq_out)
        else $error("interrupt pin not raised");
    irq_clear_a: assert property (irq_rd && act_ff == 3'h0 && !(|rise) && !uc_valid |-> ##[1:2] !irq_out)
        else $error("interrupt pin not cleared by read");
    irq_hold_a: assert property (irq_out && !irq_rd && !$past(irq_rd) |=> irq_out)
        else $error("interrupt pin dropped without read");
    coef_ack_a: assert property (rd_end && paddr == 12'h1ec |=> coefficient_ack)
        else $error("no coefficient acknowledge");
    coef_cause_a: assert property (coefficient_ack |-> $past(rd_end && paddr == 12'h1ec))
        else $error("stray coefficient acknowledge");
    alarm_bits_a: assert property (rd_end && paddr == 12'h0d8 |-> prdata[2:0] ==
        $past({slot_enable_valid, slot_enabled & slot_enable_valid, superframe_unsync & slot16_signalling_on}))
        else $error("superframe alarm bits wrong");
    cover property (irq_rd && prdata != 32'h0);
    cover property (rd_end && pslverr);
    cover property (coefficient_ack);
endmodule // srb_checker
bind srb_status_regs srb_checker chk (.sys_clk, .rst, .psel, .penable, .pwrite, .pready, .pslverr, .paddr,
    .pwdata, .prdata, .watchdog_irq, .frame_sync_input, .coefficient_ready, .test_terminated, .timer_expired,
    .slot_monitor, .uc_valid, .irq_out, .coefficient_ack, .slot16_signalling_on, .slot_enable_valid,
    .slot_enabled, .superframe_unsync);

// ---- sim/srb_host_model.sv ----
// host processor model issuing apb transfers
`timescale 1ns/1ps
module srb_host_model
(
    // clock
    input  wire         sys_clk,
    // apb request
    output logic        psel = 0, penable = 0, pwrite = 0,
    output logic [11:0] paddr = 0,
    output logic [31:0] pwdata = 0,
    // apb answer
    input  wire  [31:0] prdata,
    input  wire         pready,
    input  wire         pslverr
);
    bit hang;
    // setup cycle, then access held until pready is sampled high or 20 cycles pass
    task automatic xfer(input bit w, input logic [11:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        int n;
        @(posedge sys_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do
            @(posedge sys_clk);
        while (pready !== 1'b1 && ++n < 20);
        hang = pready !== 1'b1;
        rd   = prdata;
        err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // srb_host_model

// ---- sim/tb_status_interrupt_readback.sv ----
// self-checking bench for the status readback register group
`timescale 1ns/1ps
module tb_status_interrupt_readback;
    logic        sys_clk = 0, rst = 1, err, uc_valid = 0;
    logic        slot_enable_valid = 0, slot_enabled = 0, superframe_unsync = 0;
    wire         psel, penable, pwrite, pready, pslverr, coefficient_ack, irq_out, slot16_signalling_on;
    wire  [11:0] paddr;
    wire  [31:0] pwdata, prdata;
    wire  [4:0]  frame_select;
    logic [5:0]  clk_ok = 6'h3f;
    logic [6:0]  src = 0, pat = 0;
    logic [7:0]  tf = 0, uc_data = 0;
    logic [4:0]  loss = 0, thr = 0, uc_frame = 0;
    logic [31:0] d;
    int          errors = 0, compares = 0;
    // 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;
    srb_host_model host (.sys_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    srb_status_regs DUT
    (
        .sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .ref_clock_external(clk_ok[5]), .ref_clock_normal(clk_ok[4]), .ref_clock_fallback(clk_ok[3]),
        .system_clock_input(clk_ok[2]), .clock_sixteen_mhz(clk_ok[1]), .clock_thirtytwo_mhz(clk_ok[0]),
        .watchdog_irq(src[6]), .frame_sync_input(src[5]), .coefficient_ready(src[4]),
        .test_terminated(src[3]), .timer_expired(src[2]), .slot_monitor(src[0]), .coefficient_ack,
        .slot_enable_valid, .slot_enabled, .superframe_unsync, .test_output_pattern(pat),
        .tone_phase_reversal(tf[7]), .answer_tone_seen(tf[6]), .nonlinear_processor_on(tf[5]),
        .filter_frozen(tf[4]), .filter_cleared(tf[3]), .echo_loss_level(loss), .fast_convergence(tf[1]),
        .silence_detected(tf[0]), .bypass_threshold(thr), .uc_valid, .uc_frame, .uc_data,
        .irq_out, .slot16_signalling_on, .frame_select
    );
    // compare and count
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // closing report
    task automatic give_verdict;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // bus access, a hang ends the run
    task automatic xfer(input bit w, input logic [11:0] a, input logic [31:0] wd);
        host.xfer(w, a, wd, d, err);
        if (host.hang)
        begin
            errors++;
            give_verdict;
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        xfer(0, a, 0);
        chk($sformatf("reg %h", a), d, e);
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // one user-channel sample
    task automatic uc_send(input logic [7:0] v);
        uc_frame <= 5'h03;
        uc_data  <= v;
        uc_valid <= 1;
        step(1);
        uc_valid <= 0;
        step(3);
    endtask
    // main sequence
    initial
    begin
        step(6);
        rst <= 0;
        rd(12'h200, 0);
        rd(12'h020, 0);
        rd(12'h3fc, 0);
        chk("slverr", err, 1);
        for (int i = 0; i < 6; i++)
        begin
            clk_ok <= ~(6'h01 << i);
            step(5);
            rd(12'h024, 32'h1 << i);
        end
        for (int i = 0; i < 7; i++)
            if (i != 1)
            begin
                src <= 7'h01 << i;
                step(3);
                chk("irq pin", irq_out, 1);
                rd(12'h1b8, 32'h1 << i);
                rd(12'h020, 32'h1 << i);
                rd(12'h020, 0);
                chk("irq pin", irq_out, 0);
                src <= 0;
                step(3);
                rd(12'h1b8, 0);
            end
        xfer(0, 12'h1ec, 0);
        xfer(1, 12'h200, 32'h7f);
        src <= 7'h7d;
        step(3);
        rd(12'h020, 0);
        rd(12'h1b8, 32'h7d);
        src <= 0;
        xfer(1, 12'h200, 0);
        for (int i = 0; i < 16; i++)
        begin
            xfer(1, 12'h204, {26'h0, i[3], 5'h0});
            {slot_enable_valid, slot_enabled, superframe_unsync} <= i[2:0];
            step(2);
            rd(12'h0d8, {29'h0, i[2], i[2] & i[1], i[0] & i[3]});
        end
        pat <= 7'h5a;
        xfer(1, 12'h0f4, 32'hff);
        rd(12'h0f4, 32'h5a);
        for (int i = 0; i < 8; i++)
            if (i != 2)
            begin
                tf <= (i == 7) ? 8'hc0 : 8'h01 << i;
                step(2);
                rd(12'h0f8, (i == 7) ? 32'hc0 : 32'h1 << i);
            end
        tf   <= 0;
        thr  <= 5'h0c;
        loss <= 5'h0c;
        step(2);
        rd(12'h0f8, 0);
        loss <= 5'h0d;
        step(2);
        rd(12'h0f8, 32'h04);
        xfer(1, 12'h204, 32'h03);
        uc_send(8'h11);
        xfer(0, 12'h020, 0);
        xfer(0, 12'h1a8, 0);
        rd(12'h19c, 32'h11);
        uc_send(8'ha5);
        chk("irq pin", irq_out, 1);
        rd(12'h1b8, 32'h02);
        rd(12'h020, 32'h02);
        rd(12'h1a0, 32'h11);
        rd(12'h1a4, 32'ha5);
        rd(12'h1a8, 32'h03);
        rd(12'h1b8, 0);
        rd(12'h19c, 32'ha5);
        chk("frame select", {27'h0, frame_select}, 3);
        give_verdict;
    end
endmodule // tb_status_interrupt_readback
